//--- rshr_pkg.sv
`default_nettype none
package rshr_pkg;
	// ==========================================================
	// sizes
	localparam int NUM_PORTS = 4;
	localparam int NUM_GRPS = 2;
	localparam int NUM_SLOTS = 4;
	// ==========================================================
	// tag identifiers
	localparam logic [15:0] ETYPE_RTAG = 16'hf1c1;
	localparam logic [15:0] ETYPE_CTAG = 16'h8100;
	localparam logic [15:0] ETYPE_STAG = 16'h88a8;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_COMMON = 8'h00;
	localparam logic [7:0] OFS_GRP_BASE = 8'h04;
	localparam logic [7:0] OFS_PORT_BASE = 8'h10;
	localparam logic [7:0] OFS_POP_CNT = 8'h20;
	localparam logic [7:0] OFS_PUSH_CNT = 8'h24;
	// ==========================================================
	// field positions
	localparam int COM_AWARE_BIT = 0;
	localparam int COM_UNIT_LSB = 8;
	localparam int COM_STATDIS_BIT = 16;
	localparam int GRP_TTL_LSB = 0;
	localparam int GRP_LRNHP_BIT = 8;
	localparam int GRP_MODE_BIT = 9;
	localparam int PRT_GRP_BIT = 0;
	localparam int PRT_HDR_BIT = 1;
	localparam int PRT_PAD_BIT = 2;
	localparam int PRT_MIRROR_BIT = 3;
	localparam int PRT_MISC_BIT = 4;
	// writable bits of the common, group and port registers
	localparam logic [31:0] COM_MASK = 32'h0001_1f01;
	localparam logic [31:0] GRP_MASK = 32'h0000_031f;
	localparam logic [31:0] PRT_MASK = 32'h0000_001f;
	// reset values
	localparam logic [31:0] COM_RESET = 32'h0000_0000;
	localparam logic [31:0] GRP_RESET = 32'h0000_0000;
	localparam logic [31:0] PRT_RESET = 32'h0000_0000;
	// ==========================================================
	// frame lengths and priorities
	localparam logic [6:0] MIN_LEN_PLAIN = 7'd64;
	localparam logic [6:0] MIN_LEN_PAD = 7'd76;
	localparam logic [2:0] QOS_HIGHEST = 3'h7;
	localparam logic [1:0] MAX_PUSH = 2'h3;
	// ==========================================================
	// forwarding modes
	localparam logic [2:0] FWD_LOOKUP = 3'h0;
	localparam logic [2:0] FWD_LOGICAL = 3'h1;
	localparam logic [2:0] MULTICAST_FORWARDING = 3'h2;
	localparam logic [2:0] FWD_GMIRROR = 3'h3;
	// ==========================================================
	typedef struct packed {
		logic valid;
		logic [1:0] port;
		logic [NUM_SLOTS-1:0][15:0] tag_type;
		logic avail;
		logic pop_ena;
		logic [1:0] push_sel;
		logic [1:0] pop_cnt;
		logic [1:0] push_cnt;
		logic [2:0] fwd_mode;
		logic learn_all;
		logic [2:0] qos;
	} rshr_desc_s;
	typedef struct packed {
		logic valid;
		logic [1:0] rtag_pos;
		logic [1:0] vlan_cnt;
		logic rtag_pop;
		logic rtag_keep;
		logic [2:0] rtag_out_pos;
		logic [1:0] rtag_push_pos;
		logic seq_replace;
		logic [1:0] vlan_push;
		logic hdr_insert;
		logic [4:0] ttl;
		logic [4:0] unit_id;
		logic [2:0] qos;
		logic [2:0] fwd_mode;
		logic misc_isdx;
		logic mirror_obey;
		logic egress_service_index_count_ena;
		logic [6:0] min_len;
	} rshr_res_s;
endpackage
`default_nettype wire

//--- rshr_top.sv
// Behaviour
// - unaware: tag is ethertype, front VLANs parsed
// - find tag outer/middle/inner, three VLANs
// - position codes 0 none, 1..3 outer..inner
// - no pop unless front VLANs popped
// - unpopped tag stays unmodified
// - pop when possible, enabled and available
// - transparent tag innermost or stays put
// - push only after pop or absent tag
// - three pushes total, tag replaces VLAN
// - push position 1 outer 2 middle 3 inner
// - pop plus push replaces sequence number
// - configurable own unit identifier
// - per-port stacking header insert enable
// - padding gives 76 byte minimum, else 64
// - mirror tagging only front ports, gmirror
// - per-port misc field decode select
// - port picks one of two groups
// - learn-all priority forces qos seven
// - mode 0 translates logical/mc to lookup
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rshr_top
	import rshr_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [3:0] wb_sel_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire rshr_desc_s desc_in,
	output rshr_res_s res_out
);
	// ==========================================================
	// register file
	logic [31:0] common_reg;
	logic [31:0] grp_reg [NUM_GRPS];
	logic [31:0] port_reg [NUM_PORTS];
	logic [15:0] pop_count_reg;
	logic [15:0] push_count_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic wb_take;
	logic wb_write;
	logic [31:0] rdata_next;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
			input logic [3:0] sel, input logic [31:0] msk);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & msk;
		return (old & ~m) | (dat & m);
	endfunction

	assign wb_take = wb_cyc_in & wb_stb_in & ~ack_reg;
	// writes land on the edge that sees ack, while the master still holds its data
	assign wb_write = wb_cyc_in & wb_stb_in & wb_we_in & ack_reg;

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= wb_take;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			common_reg <= COM_RESET;
		end else if (wb_write && wb_adr_in == OFS_COMMON) begin
			common_reg <= merge(common_reg, wb_dat_in, wb_sel_in, COM_MASK);
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_GRPS; gi++) begin : g_grp
			always_ff @(posedge core_clk_in or posedge reset_in) begin
				if (reset_in) begin
					grp_reg[gi] <= GRP_RESET;
				end else if (wb_write && wb_adr_in == OFS_GRP_BASE + 8'(4 * gi)) begin
					grp_reg[gi] <= merge(grp_reg[gi], wb_dat_in, wb_sel_in, GRP_MASK);
				end
			end
		end
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
			always_ff @(posedge core_clk_in or posedge reset_in) begin
				if (reset_in) begin
					port_reg[gi] <= PRT_RESET;
				end else if (wb_write && wb_adr_in == OFS_PORT_BASE + 8'(4 * gi)) begin
					port_reg[gi] <= merge(port_reg[gi], wb_dat_in, wb_sel_in, PRT_MASK);
				end
			end
		end
	endgenerate

	always_comb begin
		rdata_next = 32'h0000_0000;
		if (wb_adr_in == OFS_COMMON) begin
			rdata_next = common_reg;
		end
		if (wb_adr_in == OFS_POP_CNT) begin
			rdata_next = {16'h0000, pop_count_reg};
		end
		if (wb_adr_in == OFS_PUSH_CNT) begin
			rdata_next = {16'h0000, push_count_reg};
		end
		for (int i = 0; i < NUM_GRPS; i++) begin
			if (wb_adr_in == OFS_GRP_BASE + 8'(4 * i)) begin
				rdata_next = grp_reg[i];
			end
		end
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (wb_adr_in == OFS_PORT_BASE + 8'(4 * i)) begin
				rdata_next = port_reg[i];
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_reg <= 32'h0000_0000;
		end else if (wb_take && !wb_we_in) begin
			rdata_reg <= rdata_next;
		end
	end

	assign wb_ack_out = ack_reg;
	assign wb_dat_out = rdata_reg;

	// ==========================================================
	// configuration fields
	logic aware;
	logic stat_dis;
	logic [4:0] unit_id;
	logic [31:0] pcfg;
	logic [31:0] gcfg;

	assign aware = common_reg[COM_AWARE_BIT];
	assign stat_dis = common_reg[COM_STATDIS_BIT];
	assign unit_id = common_reg[COM_UNIT_LSB +: 5];
	assign pcfg = port_reg[desc_in.port];
	assign gcfg = grp_reg[pcfg[PRT_GRP_BIT]];

	// ==========================================================
	// tag parser
	logic [1:0] rpos;
	logic [1:0] vcnt;
	logic done;

	always_comb begin
		rpos = 2'h0;
		vcnt = 2'h0;
		done = 1'b0;
		for (int i = 0; i < NUM_SLOTS; i++) begin
			if (!done) begin
				if ((desc_in.tag_type[i] == ETYPE_CTAG || desc_in.tag_type[i] == ETYPE_STAG)
						&& vcnt < ((rpos != 2'h0) ? 2'h2 : 2'h3)) begin
					vcnt = vcnt + 2'h1;
				end else if (desc_in.tag_type[i] == ETYPE_RTAG && aware && rpos == 2'h0
						&& i < NUM_SLOTS - 1 && vcnt < 2'h3) begin
					rpos = 2'(i + 1);
				end else begin
					done = 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// redundancy tag actions
	logic present;
	logic pop_possible;
	logic do_pop;
	logic do_push;
	logic keep;
	logic [2:0] out_pos;
	logic [1:0] vpush;
	logic [1:0] push_tot;

	assign present = rpos != 2'h0 && desc_in.avail;
	assign pop_possible = present && desc_in.pop_cnt >= rpos - 2'h1;
	assign do_pop = pop_possible && desc_in.pop_ena;
	assign do_push = desc_in.push_sel != 2'h0 && (do_pop || !desc_in.avail);
	assign keep = present && !do_pop;
	assign push_tot = (desc_in.push_cnt > MAX_PUSH) ? MAX_PUSH : desc_in.push_cnt;
	// pushed tag takes one of the pushed VLAN slots
	assign vpush = (do_push && push_tot != 2'h0) ? push_tot - 2'h1 : push_tot;

	always_comb begin
		out_pos = 3'h0;
		if (keep) begin
			if (pop_possible) begin
				out_pos = {1'b0, vpush} + 3'h1;
			end else begin
				out_pos = {1'b0, vpush} + {1'b0, rpos} - {1'b0, desc_in.pop_cnt};
			end
		end
	end

	// ==========================================================
	// stacking header fields
	logic hdr_ena;
	logic [2:0] fwd_next;
	logic [2:0] qos_next;

	assign hdr_ena = pcfg[PRT_HDR_BIT];

	always_comb begin
		fwd_next = desc_in.fwd_mode;
		if (!gcfg[GRP_MODE_BIT] && (desc_in.fwd_mode == FWD_LOGICAL ||
				desc_in.fwd_mode == MULTICAST_FORWARDING)) begin
			fwd_next = FWD_LOOKUP;
		end
	end

	assign qos_next = (gcfg[GRP_LRNHP_BIT] && desc_in.learn_all) ? QOS_HIGHEST : desc_in.qos;

	// ==========================================================
	// result register
	rshr_res_s res_reg;

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			res_reg <= '0;
		end else begin
			res_reg.valid <= desc_in.valid;
			res_reg.rtag_pos <= rpos;
			res_reg.vlan_cnt <= vcnt;
			res_reg.rtag_pop <= do_pop;
			res_reg.rtag_keep <= keep;
			res_reg.rtag_out_pos <= out_pos;
			res_reg.rtag_push_pos <= do_push ? desc_in.push_sel : 2'h0;
			res_reg.seq_replace <= do_pop && do_push;
			res_reg.vlan_push <= vpush;
			res_reg.hdr_insert <= hdr_ena;
			res_reg.ttl <= gcfg[GRP_TTL_LSB +: 5];
			res_reg.unit_id <= unit_id;
			res_reg.qos <= qos_next;
			res_reg.fwd_mode <= fwd_next;
			res_reg.misc_isdx <= pcfg[PRT_MISC_BIT];
			res_reg.mirror_obey <= !hdr_ena && desc_in.fwd_mode == FWD_GMIRROR
				&& pcfg[PRT_MIRROR_BIT];
			res_reg.egress_service_index_count_ena <= !(stat_dis && hdr_ena);
			res_reg.min_len <= pcfg[PRT_PAD_BIT] ? MIN_LEN_PAD : MIN_LEN_PLAIN;
		end
	end

	assign res_out = res_reg;

	// ==========================================================
	// activity counters
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pop_count_reg <= 16'h0000;
		end else if (desc_in.valid && do_pop) begin
			pop_count_reg <= pop_count_reg + 16'h0001;
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			push_count_reg <= 16'h0000;
		end else if (desc_in.valid && do_push) begin
			push_count_reg <= push_count_reg + 16'h0001;
		end
	end

	// ==========================================================
	// assertions
	property p_no_pop_front;
		@(posedge core_clk_in) disable iff (reset_in)
		res_out.rtag_pop |-> res_out.rtag_pos != 2'h0
			&& $past(desc_in.pop_cnt) >= res_out.rtag_pos - 2'h1;
	endproperty
	a_no_pop_front: assert property (p_no_pop_front)
		else $error("tag popped with no tag present");

	property p_pop_front;
		@(posedge core_clk_in) disable iff (reset_in)
		desc_in.pop_ena && desc_in.avail && rpos == 2'h2 && desc_in.pop_cnt != 2'h0
			|=> res_out.rtag_pop;
	endproperty
	a_pop_front: assert property (p_pop_front)
		else $error("middle tag not popped although possible");

	property p_keep;
		@(posedge core_clk_in) disable iff (reset_in)
		res_out.rtag_keep |-> !res_out.rtag_pop && res_out.rtag_push_pos == 2'h0;
	endproperty
	a_keep: assert property (p_keep)
		else $error("kept tag also popped or pushed");

	property p_replace;
		@(posedge core_clk_in) disable iff (reset_in)
		res_out.seq_replace |-> res_out.rtag_pop && res_out.rtag_push_pos != 2'h0;
	endproperty
	a_replace: assert property (p_replace)
		else $error("sequence replace without pop and push");

	property p_pos_range;
		@(posedge core_clk_in) disable iff (reset_in)
		res_out.rtag_pos == 2'h3 |-> res_out.vlan_cnt == 2'h2;
	endproperty
	a_pos_range: assert property (p_pos_range)
		else $error("inner position without two vlan tags");

	property p_unaware;
		@(posedge core_clk_in) disable iff (reset_in)
		!aware |=> res_out.rtag_pos == 2'h0;
	endproperty
	a_unaware: assert property (p_unaware)
		else $error("tag located while awareness is off");

	property p_pad;
		@(posedge core_clk_in) disable iff (reset_in)
		pcfg[PRT_PAD_BIT] |=> res_out.min_len == MIN_LEN_PAD;
	endproperty
	a_pad: assert property (p_pad)
		else $error("padded port minimum length wrong");

	property p_qos;
		@(posedge core_clk_in) disable iff (reset_in)
		gcfg[GRP_LRNHP_BIT] && desc_in.learn_all |=> res_out.qos == QOS_HIGHEST;
	endproperty
	a_qos: assert property (p_qos)
		else $error("learn-all frame not raised to top priority");

	property p_translate;
		@(posedge core_clk_in) disable iff (reset_in)
		!gcfg[GRP_MODE_BIT] && desc_in.fwd_mode == MULTICAST_FORWARDING |=> res_out.fwd_mode == FWD_LOOKUP;
	endproperty
	a_translate: assert property (p_translate)
		else $error("multicast mode not translated");

	property p_count;
		@(posedge core_clk_in) disable iff (reset_in)
		stat_dis && hdr_ena |=> !res_out.egress_service_index_count_ena;
	endproperty
	a_count: assert property (p_count)
		else $error("service counting not suppressed");

	property p_mirror;
		@(posedge core_clk_in) disable iff (reset_in)
		hdr_ena |=> !res_out.mirror_obey;
	endproperty
	a_mirror: assert property (p_mirror)
		else $error("mirror tagging active on stacking port");

	property p_push_needs_pop;
		@(posedge core_clk_in) disable iff (reset_in)
		res_out.rtag_push_pos != 2'h0 |-> res_out.rtag_pop || !$past(desc_in.avail);
	endproperty
	a_push_needs_pop: assert property (p_push_needs_pop)
		else $error("tag pushed while the ingress tag stays");

	property p_keep_pos;
		@(posedge core_clk_in) disable iff (reset_in)
		res_out.rtag_keep |-> res_out.rtag_out_pos != 3'h0;
	endproperty
	a_keep_pos: assert property (p_keep_pos)
		else $error("kept tag given no egress position");

	property p_plain_len;
		@(posedge core_clk_in) disable iff (reset_in)
		!pcfg[PRT_PAD_BIT] |=> res_out.min_len == MIN_LEN_PLAIN;
	endproperty
	a_plain_len: assert property (p_plain_len)
		else $error("unpadded port minimum length wrong");

	property p_ack;
		@(posedge core_clk_in) disable iff (reset_in)
		wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
	endproperty
	a_ack: assert property (p_ack)
		else $error("bus answer not a single cycle after request");
endmodule
`default_nettype wire

//--- rshr_analyzer_model.sv
`timescale 1ns/1ps
`default_nettype none
module rshr_analyzer_model
	import rshr_pkg::*;
(
	input wire logic clk_in,
	output rshr_desc_s desc_out
);
	initial begin
		desc_out = '0;
	end
	// ==========================================================
	// availability flag: tag in slots 0..2 with only VLANs ahead
	function automatic logic tag_seen(input logic [NUM_SLOTS-1:0][15:0] t);
		logic ok;
		ok = 1'b1;
		tag_seen = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (ok && t[i] == ETYPE_RTAG) tag_seen = 1'b1;
			ok = ok && (t[i] == ETYPE_CTAG || t[i] == ETYPE_STAG);
		end
	endfunction
	// ==========================================================
	// one frame for one cycle, then an idle descriptor with no stale tags
	task automatic send(input rshr_desc_s d);
		rshr_desc_s x;
		x = d;
		x.valid = 1'b1;
		x.avail = tag_seen(d.tag_type);
		@(posedge clk_in);
		desc_out <= x;
		@(posedge clk_in);
		x.valid = 1'b0;
		x.tag_type = ~x.tag_type;
		desc_out <= x;
		#1;
	endtask
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import rshr_pkg::*;
;
	localparam logic [15:0] V = ETYPE_CTAG;
	localparam logic [15:0] R = ETYPE_RTAG;
	localparam logic [15:0] E = 16'h0800;
	localparam logic [63:0] NT = {E, E, E, E};
	logic core_clk_in, reset_in, wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0] wb_adr;
	logic [31:0] wb_dat, wb_rd, rdat;
	logic [3:0] wb_sel;
	rshr_desc_s desc;
	rshr_res_s res;
	int failures = 0;
	int samples_checked = 0;
	logic [63:0] pt [4];
	rshr_top rshr_top_i(.core_clk_in(core_clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc),
		.wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_dat_in(wb_dat),
		.wb_sel_in(wb_sel), .wb_dat_out(wb_rd), .wb_ack_out(wb_ack), .desc_in(desc),
		.res_out(res));
	rshr_analyzer_model rshr_analyzer_model_i(.clk_in(core_clk_in), .desc_out(desc));
	initial begin
		core_clk_in = 1'b0;
		forever #50 core_clk_in = ~core_clk_in;
	end
	// ==========================================================
	// report and bus tasks
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge core_clk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= s;
		n = 0;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (wb_ack !== 1'b1) begin
			failures++;
			$display("Error bus ack expected 1 seen %b", wb_ack);
			tally_and_finish();
		end else begin
			rdat = wb_rd;
			wb_cyc <= 1'b0;
			wb_stb <= 1'b0;
		end
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hf);
		chk(n, e, rdat);
	endtask
	task automatic frm(input logic [63:0] t, input logic pe, input logic [1:0] ps, pc, qc,
		port, input logic [2:0] fw, input logic la);
		rshr_desc_s d;
		d = '0;
		d.tag_type = t;
		d.pop_ena = pe;
		d.push_sel = ps;
		d.pop_cnt = pc;
		d.push_cnt = qc;
		d.port = port;
		d.fwd_mode = fw;
		d.learn_all = la;
		d.qos = 3'h2;
		rshr_analyzer_model_i.send(d);
		chk("valid", 32'h1, res.valid);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		reset_in = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_dat = 32'h0;
		wb_sel = 4'h0;
		pt = '{{E, V, V, V}, {E, V, V, R}, {E, V, R, V}, {E, R, V, V}};
		repeat (20) @(posedge core_clk_in);
		reset_in <= 1'b0;
		rd("common", OFS_COMMON, COM_RESET);
		rd("group1", OFS_GRP_BASE + 8'h04, GRP_RESET);
		rd("port3", OFS_PORT_BASE + 8'h0c, PRT_RESET);
		wb(1'b1, OFS_COMMON, 32'hffff_ffff, 4'hf);
		rd("common", OFS_COMMON, COM_MASK);
		wb(1'b1, OFS_GRP_BASE, 32'hffff_ffff, 4'h1);
		rd("group0 lane", OFS_GRP_BASE, 32'h0000_001f);
		wb(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
		rd("unmapped", 8'h40, 32'h0);
		wb(1'b1, OFS_PUSH_CNT, 32'hffff_ffff, 4'hf);
		rd("push count", OFS_PUSH_CNT, 32'h0);
		$display("test registers done");
		wb(1'b1, OFS_COMMON, 32'h1, 4'hf);
		wb(1'b1, OFS_GRP_BASE, 32'h0, 4'hf);
		for (int i = 0; i < 4; i++) begin
			frm(pt[i], 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, FWD_LOOKUP, 1'b0);
			chk("position", 32'(i), res.rtag_pos);
			chk("vlans", (i == 0) ? 32'h3 : 32'h2, res.vlan_cnt);
			chk("keep", 32'(i != 0), res.rtag_keep);
			chk("out position", 32'(i), res.rtag_out_pos);
		end
		wb(1'b1, OFS_COMMON, 32'h0, 4'hf);
		frm(pt[1], 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, FWD_LOOKUP, 1'b0);
		chk("unaware pos", 32'h0, res.rtag_pos);
		chk("unaware vlans", 32'h0, res.vlan_cnt);
		frm(pt[2], 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, FWD_LOOKUP, 1'b0);
		chk("unaware vlans", 32'h1, res.vlan_cnt);
		$display("test parsing done");
		wb(1'b1, OFS_COMMON, 32'h1, 4'hf);
		frm(pt[2], 1'b1, 2'h0, 2'h0, 2'h0, 2'h0, FWD_LOOKUP, 1'b0);
		chk("pop blocked", 32'h0, res.rtag_pop);
		chk("kept", 32'h1, res.rtag_keep);
		frm(pt[2], 1'b1, 2'h2, 2'h1, 2'h2, 2'h0, FWD_LOOKUP, 1'b0);
		chk("pop", 32'h1, res.rtag_pop);
		chk("push pos", 32'h2, res.rtag_push_pos);
		chk("seq replace", 32'h1, res.seq_replace);
		chk("vlan push", 32'h1, res.vlan_push);
		frm(pt[2], 1'b0, 2'h3, 2'h0, 2'h1, 2'h0, FWD_LOOKUP, 1'b0);
		chk("no push", 32'h0, res.rtag_push_pos);
		frm(pt[2], 1'b0, 2'h0, 2'h1, 2'h2, 2'h0, FWD_LOOKUP, 1'b0);
		chk("innermost", 32'h3, res.rtag_out_pos);
		for (int p = 1; p < 4; p++) begin
			frm(NT, 1'b0, 2'(p), 2'h0, 2'h3, 2'h0, FWD_LOOKUP, 1'b0);
			chk("push pos", 32'(p), res.rtag_push_pos);
			chk("vlan push", 32'h2, res.vlan_push);
		end
		$display("test pop and push done");
		wb(1'b1, OFS_COMMON, 32'h0001_0a00, 4'hf);
		wb(1'b1, OFS_GRP_BASE, 32'h0000_0200, 4'hf);
		wb(1'b1, OFS_GRP_BASE + 8'h04, 32'h0000_0115, 4'hf);
		wb(1'b1, OFS_PORT_BASE + 8'h04, 32'h0000_0017, 4'hf);
		wb(1'b1, OFS_PORT_BASE + 8'h08, 32'h0000_0008, 4'hf);
		frm(NT, 1'b0, 2'h0, 2'h0, 2'h0, 2'h1, FWD_LOGICAL, 1'b1);
		chk("hdr", 32'h1, res.hdr_insert);
		chk("ttl", 32'h15, res.ttl);
		chk("unit", 32'h0a, res.unit_id);
		chk("qos", 32'(QOS_HIGHEST), res.qos);
		chk("fwd", 32'(FWD_LOOKUP), res.fwd_mode);
		chk("min len", 32'(MIN_LEN_PAD), res.min_len);
		chk("misc", 32'h1, res.misc_isdx);
		chk("count ena", 32'h0, res.egress_service_index_count_ena);
		frm(NT, 1'b0, 2'h0, 2'h0, 2'h0, 2'h1, MULTICAST_FORWARDING, 1'b0);
		chk("fwd", 32'(FWD_LOOKUP), res.fwd_mode);
		chk("qos", 32'h2, res.qos);
		frm(NT, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, MULTICAST_FORWARDING, 1'b0);
		chk("fwd", 32'(MULTICAST_FORWARDING), res.fwd_mode);
		chk("hdr", 32'h0, res.hdr_insert);
		chk("min len", 32'(MIN_LEN_PLAIN), res.min_len);
		chk("count ena", 32'h1, res.egress_service_index_count_ena);
		chk("ttl", 32'h0, res.ttl);
		frm(NT, 1'b0, 2'h0, 2'h0, 2'h0, 2'h2, FWD_GMIRROR, 1'b0);
		chk("mirror", 32'h1, res.mirror_obey);
		frm(NT, 1'b0, 2'h0, 2'h0, 2'h0, 2'h2, FWD_LOOKUP, 1'b0);
		chk("mirror", 32'h0, res.mirror_obey);
		wb(1'b1, OFS_PORT_BASE + 8'h0c, 32'h0000_000a, 4'hf);
		frm(NT, 1'b0, 2'h0, 2'h0, 2'h0, 2'h3, FWD_GMIRROR, 1'b0);
		chk("mirror", 32'h0, res.mirror_obey);
		chk("hdr", 32'h1, res.hdr_insert);
		chk("count ena", 32'h0, res.egress_service_index_count_ena);
		$display("test stacking done");
		rd("pop count", OFS_POP_CNT, 32'h1);
		rd("push count", OFS_PUSH_CNT, 32'h4);
		@(posedge core_clk_in);
		reset_in <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		reset_in <= 1'b0;
		rd("common after reset", OFS_COMMON, COM_RESET);
		rd("port after reset", OFS_PORT_BASE + 8'h04, PRT_RESET);
		rd("pop count after reset", OFS_POP_CNT, 32'h0);
		$display("test counters and reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
